// ===== hw/mrs_pkg.sv
// constants, types and register map of the reset sequencer
package mrs_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 10_000_000;
	localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;
	localparam int unsigned PIN_DELAY_NS  = 5000;   // pin to internal reset delay
	localparam int unsigned PROC_TIME_NS  = 11000;  // reset processing, least figure
	localparam int unsigned HIOSC_STAB_NS = 86000;  // oscillator accuracy wait, least figure
	localparam int unsigned PIN_DELAY_CYC  = (PIN_DELAY_NS * CLK_PER_US + 999) / 1000;
	localparam int unsigned PROC_TIME_CYC  = (PROC_TIME_NS * CLK_PER_US + 999) / 1000;
	localparam int unsigned HIOSC_STAB_CYC = (HIOSC_STAB_NS * CLK_PER_US + 999) / 1000;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CLK_CTL  = 8'h00;
	localparam logic [7:0] OFF_CLK_MODE = 8'h04;
	localparam logic [7:0] OFF_PORT_LAT = 8'h08;
	localparam logic [7:0] OFF_PORT_DIR = 8'h0C;
	localparam logic [7:0] OFF_MEM_SIZE = 8'h10;
	localparam logic [7:0] OFF_CORE     = 8'h14;
	localparam logic [7:0] OFF_TMR_CNT  = 8'h18;
	localparam logic [7:0] OFF_TMR_CTL  = 8'h1C;
	localparam logic [7:0] OFF_STATUS   = 8'h20;

	// ------------------------------------------------------------
	// values applied by the internal reset, and the oscillator mode once stable
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_CPU_CLOCK_CONTROL = 8'h01;
	localparam logic [7:0]  RST_MAIN_OSC_CONTROL  = 8'h80;
	localparam logic [7:0]  RST_STAB_TIME_SELECT  = 8'h05;
	localparam logic [7:0]  RST_STAB_COUNTER      = 8'h00;
	localparam logic [7:0]  RST_CLOCK_OP_MODE     = 8'h00;
	localparam logic [7:0]  RST_MAIN_CLOCK_MODE   = 8'h00;
	localparam logic [7:0]  RST_INT_OSC_MODE      = 8'h00;
	localparam logic [7:0]  INT_OSC_MODE_STABLE   = 8'h80;
	localparam logic [7:0]  RST_PORT_LATCH        = 8'h00;
	localparam logic [7:0]  RST_PORT_DIR          = 8'hFF;
	localparam logic [7:0]  RST_MIRROR_PORT_DIR   = 8'hFE;
	localparam logic [7:0]  RST_MEMORY_SIZE       = 8'hCF;
	localparam logic [7:0]  RST_EXP_RAM_SIZE      = 8'h0C;
	localparam logic [7:0]  RST_PSW               = 8'h02;
	localparam logic [15:0] RST_TIMER_WORD        = 16'h0000;
	localparam logic [7:0]  RST_TIMER_CTL         = 8'h00;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned MOC_STOP_BIT   = 7;  // main_osc_control: 1 keeps crystal stopped
	localparam int unsigned OPM_SUBOSC_BIT = 6;  // clock_operation_mode: subsystem osc on
	localparam int unsigned OPM_EXTCLK_BIT = 7;  // clock_operation_mode: external clock in
	localparam int unsigned ST_RAM_BIT     = 3;  // status: ram kept over reset
	localparam int unsigned ST_HIOSC_BIT   = 4;  // status: oscillator accuracy reached

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		MRS_ST_RESET = 3'b001,
		MRS_ST_PROC  = 3'b010,
		MRS_ST_RUN   = 3'b100
	} mrs_state_e;

	typedef struct packed {
		logic cpu_clk_en;     // clock supplied to the cpu
		logic hiosc_en;       // internal high-speed oscillator running
		logic hiosc_stable;   // its accuracy wait is over
		logic x1_en;          // main crystal oscillator running
		logic subosc_en;      // subsystem crystal running
		logic lowosc_en;      // internal low-speed oscillator running
		logic ext_clk_valid;  // external clock inputs accepted
		logic osc_pins_port;  // oscillator pins act as plain ports
	} mrs_clk_s;

endpackage

// ===== hw/mrs_cycle_timer.sv
// cycle counter that reports when a run has lasted COUNT cycles
`timescale 1ns/1ps
`default_nettype none

module mrs_cycle_timer
#(
	parameter int unsigned COUNT = 50
)
(
	input  wire logic clk,      // system clock
	input  wire logic sys_rst,  // synchronous reset, high
	input  wire logic ce,       // clock enable
	input  wire logic run,      // count while high, clear while low
	output logic      done      // run has lasted COUNT cycles
);
	localparam int unsigned W = $clog2(COUNT + 1);
	localparam logic [W-1:0] LIMIT = W'(COUNT);

	logic [W-1:0] cnt_reg;

	// ------------------------------------------------------------
	// saturating counter
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			cnt_reg <= '0;
		else if (ce)
		begin
			if (!run)
				cnt_reg <= '0;
			else if (cnt_reg != LIMIT)
				cnt_reg <= cnt_reg + W'(1);
		end
	end

	assign done = run && (cnt_reg == LIMIT);

endmodule
`default_nettype wire

// ===== hw/mrs_reset_sequencer.sv
// reset sequencer: merges reset sources, times release, applies reset values
//
// Notes on behaviour
// - processing phase before cpu runs on oscillator
// - oscillator starts at release, accuracy after wait
// - crystal stays stopped until software starts it
// - internal reset follows pin edges after delay
// - ports float during reset and processing wait
// - mirror pin drives low when reset acts
// - watchdog overflow reset also resets watchdog
// - cpu clock and slow oscillators stop in reset
// - external clocks ignored, oscillator pins become ports
// - program counter loaded from two-byte reset vector
// - status word 02H, stack pointer left alone
// - port output latches cleared to 00H
// - directions FFH, mirror port FEH
// - clock registers take their reset values
// - timer counters and controls cleared
// - only program counter undefined during reset
// - standby reset keeps ram contents
// - memory size registers CFH and 0CH
// - oscillator mode 00H, 80H once stable
// - all reset sources act the same
// - detector reset spares detector itself
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module mrs_reset_sequencer
	import mrs_pkg::*;
#(
	parameter int unsigned PIN_DLY   = PIN_DELAY_CYC,   // pin edge delay, cycles
	parameter int unsigned PROC_CYC  = PROC_TIME_CYC,   // processing time, cycles
	parameter int unsigned STAB_CYC  = HIOSC_STAB_CYC,  // oscillator wait, cycles
	parameter int unsigned NUM_PORTS = 4                // byte-wide ports
)
(
	input  wire logic                   clk,            // system clock
	input  wire logic                   sys_rst,        // synchronous reset, high
	input  wire logic                   ce,             // clock enable
	input  wire logic                   ext_rst_n,      // external reset pin, low
	input  wire logic                   wdt_ovf,        // watchdog overflow request
	input  wire logic                   poc_req,        // power_on_clear request
	input  wire logic                   lvd_req,        // low_voltage_detector request
	input  wire logic                   standby,        // cpu is in a standby mode
	input  wire logic [7:0]             vector_lo,      // memory byte at 0000H
	input  wire logic [7:0]             vector_hi,      // memory byte at 0001H
	output logic                        core_rst,       // internal reset to the core
	output logic                        wdt_rst,        // reset to the watchdog
	output logic                        lvd_rst,        // reset to the detector
	output logic                        ram_retain,     // ram kept over this reset
	output mrs_clk_s                    clk_ctl,        // clock enables
	output logic [15:0]                 program_counter,// loaded reset vector
	output logic                        pc_load,        // pulse, counter loaded
	output logic [8*NUM_PORTS-1:0]      port_out,       // port levels, bit 0 mirror pin
	output logic [8*NUM_PORTS-1:0]      port_oe,        // port drive enables
	input  wire logic [7:0]             s_axi_awaddr,   // write address
	input  wire logic                   s_axi_awvalid,  // write address valid
	output logic                        s_axi_awready,  // write address ready
	input  wire logic [31:0]            s_axi_wdata,    // write data
	input  wire logic [3:0]             s_axi_wstrb,    // write byte enables
	input  wire logic                   s_axi_wvalid,   // write data valid
	output logic                        s_axi_wready,   // write data ready
	output logic [1:0]                  s_axi_bresp,    // write response
	output logic                        s_axi_bvalid,   // write response valid
	input  wire logic                   s_axi_bready,   // write response ready
	input  wire logic [7:0]             s_axi_araddr,   // read address
	input  wire logic                   s_axi_arvalid,  // read address valid
	output logic                        s_axi_arready,  // read address ready
	output logic [31:0]                 s_axi_rdata,    // read data
	output logic [1:0]                  s_axi_rresp,    // read response
	output logic                        s_axi_rvalid,   // read data valid
	input  wire logic                   s_axi_rready    // read data ready
);
	localparam int unsigned PW = 8 * NUM_PORTS;

	mrs_state_e      state_reg;
	logic            pin_lvl_reg;
	logic            pin_done;
	logic            proc_done;
	logic            stab_done;
	logic            int_rst;
	logic            wr_en;
	logic            wr_hit;
	logic            rd_hit;
	logic [31:0]     rd_word;
	logic [7:0]      cpu_clock_control_reg;
	logic [7:0]      main_osc_control_reg;
	logic [7:0]      stabilization_time_select_reg;
	logic [7:0]      stabilization_counter_status_reg;
	logic [7:0]      clock_operation_mode_reg;
	logic [7:0]      main_clock_mode_reg;
	logic [7:0]      internal_osc_mode_reg;
	logic [PW-1:0]   port_latch_reg;
	logic [PW-1:0]   port_direction_reg;
	logic [7:0]      memory_size_switch_reg;
	logic [7:0]      expansion_ram_size_switch_reg;
	logic [7:0]      program_status_word_reg;
	logic [15:0]     stack_pointer_reg;
	logic [15:0]     timer_count_reg;
	logic [15:0]     timer_compare_reg;
	logic [31:0]     timer_ctl_reg;

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[8*i +: 8] = d[8*i +: 8];
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// pin delay, merged request
	// ------------------------------------------------------------

	// pin level seen inside only after it has stood for the delay
	mrs_cycle_timer #(.COUNT(PIN_DLY)) u_pin_delay
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.run     (pin_lvl_reg != !ext_rst_n),
		.done    (pin_done)
	);

	// internal view of the pin follows each edge after the delay
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pin_lvl_reg <= 1'b1;
		else if (ce && pin_done)
			pin_lvl_reg <= !ext_rst_n;
	end

	// every source gives the same reset
	assign int_rst = pin_lvl_reg | wdt_ovf | poc_req | lvd_req;

	// ------------------------------------------------------------
	// sequence state
	// ------------------------------------------------------------
	mrs_cycle_timer #(.COUNT(PROC_CYC)) u_proc_timer
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.run     (state_reg == MRS_ST_PROC),
		.done    (proc_done)
	);

	mrs_cycle_timer #(.COUNT(STAB_CYC)) u_stab_timer
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.ce      (ce),
		.run     (state_reg != MRS_ST_RESET),
		.done    (stab_done)
	);

	// reset, processing wait, normal run
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			state_reg <= MRS_ST_RESET;
		else if (ce)
		begin
			unique case (state_reg)
				MRS_ST_RESET:
					if (!int_rst)
						state_reg <= MRS_ST_PROC;
				MRS_ST_PROC:
					if (int_rst)
						state_reg <= MRS_ST_RESET;
					else if (proc_done)
						state_reg <= MRS_ST_RUN;
				MRS_ST_RUN:
					if (int_rst)
						state_reg <= MRS_ST_RESET;
				default:
					state_reg <= MRS_ST_RESET;
			endcase
		end
	end

	// reset outputs to core, watchdog and detector
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			core_rst <= 1'b1;
			wdt_rst  <= 1'b1;
			lvd_rst  <= 1'b1;
		end
		else if (ce)
		begin
			core_rst <= int_rst;
			wdt_rst  <= int_rst;
			lvd_rst  <= pin_lvl_reg | wdt_ovf | poc_req;
		end
	end

	// ram kept when the reset hits a standby cpu
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ram_retain <= 1'b0;
		else if (ce && int_rst && state_reg == MRS_ST_RUN)
			ram_retain <= standby;
	end

	// program counter taken from the vector as the cpu starts
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			program_counter <= 16'h0000;
			pc_load         <= 1'b0;
		end
		else if (ce)
		begin
			pc_load <= 1'b0;
			if (state_reg == MRS_ST_PROC && proc_done && !int_rst)
			begin
				program_counter <= {vector_hi, vector_lo};
				pc_load         <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// clocks and pins
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			clk_ctl <= mrs_clk_s'(8'h01);  // all stopped, oscillator pins as ports
		else if (ce)
		begin
			clk_ctl.cpu_clk_en    <= !int_rst && state_reg == MRS_ST_RUN;
			clk_ctl.hiosc_en      <= !int_rst && state_reg != MRS_ST_RESET;
			clk_ctl.hiosc_stable  <= !int_rst && stab_done;
			clk_ctl.x1_en         <= !int_rst && !main_osc_control_reg[MOC_STOP_BIT];
			clk_ctl.subosc_en     <= !int_rst && clock_operation_mode_reg[OPM_SUBOSC_BIT];
			clk_ctl.lowosc_en     <= !int_rst && state_reg != MRS_ST_RESET;
			clk_ctl.ext_clk_valid <= !int_rst && clock_operation_mode_reg[OPM_EXTCLK_BIT];
			clk_ctl.osc_pins_port <= int_rst || !clock_operation_mode_reg[OPM_SUBOSC_BIT];
		end
	end

	// ports float until run, mirror pin driven low meanwhile
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			port_out <= '0;
			port_oe  <= PW'(1);
		end
		else if (ce)
		begin
			if (int_rst || state_reg != MRS_ST_RUN)
			begin
				port_out <= '0;
				port_oe  <= PW'(1);
			end
			else
			begin
				port_out <= port_latch_reg;
				port_oe  <= ~port_direction_reg;
			end
		end
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	assign wr_en = s_axi_awready && s_axi_wready;

	// reset values applied whenever the internal reset stands
	always_ff @(posedge clk)
	begin
		if (sys_rst || (ce && int_rst))
		begin
			cpu_clock_control_reg            <= RST_CPU_CLOCK_CONTROL;
			main_osc_control_reg             <= RST_MAIN_OSC_CONTROL;
			stabilization_time_select_reg    <= RST_STAB_TIME_SELECT;
			stabilization_counter_status_reg <= RST_STAB_COUNTER;
			clock_operation_mode_reg         <= RST_CLOCK_OP_MODE;
			main_clock_mode_reg              <= RST_MAIN_CLOCK_MODE;
			port_latch_reg                   <= {NUM_PORTS{RST_PORT_LATCH}};
			port_direction_reg <= {{(NUM_PORTS-1){RST_PORT_DIR}}, RST_MIRROR_PORT_DIR};
			memory_size_switch_reg           <= RST_MEMORY_SIZE;
			expansion_ram_size_switch_reg    <= RST_EXP_RAM_SIZE;
			program_status_word_reg          <= RST_PSW;
			timer_count_reg                  <= RST_TIMER_WORD;
			timer_compare_reg                <= RST_TIMER_WORD;
			timer_ctl_reg                    <= {4{RST_TIMER_CTL}};
		end
		else if (ce && wr_en)
		begin
			// other state held until a write; nothing else changes in reset
			unique case (s_axi_awaddr)
				OFF_CLK_CTL:
					{stabilization_time_select_reg, main_osc_control_reg,
						cpu_clock_control_reg} <= 24'(merge({8'h00,
						stabilization_time_select_reg, main_osc_control_reg,
						cpu_clock_control_reg}, s_axi_wdata, s_axi_wstrb));
				OFF_CLK_MODE:
					{main_clock_mode_reg, clock_operation_mode_reg} <= 16'(merge({16'h0000,
						main_clock_mode_reg, clock_operation_mode_reg},
						s_axi_wdata, s_axi_wstrb));
				OFF_PORT_LAT:
					port_latch_reg <= PW'(merge(32'(port_latch_reg), s_axi_wdata, s_axi_wstrb));
				OFF_PORT_DIR:
					port_direction_reg <= PW'(merge(32'(port_direction_reg), s_axi_wdata,
						s_axi_wstrb));
				OFF_MEM_SIZE:
					{expansion_ram_size_switch_reg, memory_size_switch_reg} <= 16'(merge(
						{16'h0000, expansion_ram_size_switch_reg, memory_size_switch_reg},
						s_axi_wdata, s_axi_wstrb));
				OFF_CORE:
					program_status_word_reg <= 8'(merge({24'h000000, program_status_word_reg},
						s_axi_wdata, s_axi_wstrb));
				OFF_TMR_CNT:
					{timer_compare_reg, timer_count_reg} <= merge({timer_compare_reg,
						timer_count_reg}, s_axi_wdata, s_axi_wstrb);
				OFF_TMR_CTL:
					timer_ctl_reg <= merge(timer_ctl_reg, s_axi_wdata, s_axi_wstrb);
				default:
					timer_ctl_reg <= timer_ctl_reg;
			endcase
		end
	end

	// stack pointer never touched by the internal reset
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			stack_pointer_reg <= 16'h0000;
		else if (ce && wr_en && !int_rst && s_axi_awaddr == OFF_CORE)
			stack_pointer_reg <= 16'(merge({stack_pointer_reg, 16'h0000}, s_axi_wdata,
				s_axi_wstrb) >> 16);
	end

	// oscillator mode reads 00H until the accuracy wait is over
	always_ff @(posedge clk)
	begin
		if (sys_rst || (ce && int_rst))
			internal_osc_mode_reg <= RST_INT_OSC_MODE;
		else if (ce && stab_done)
			internal_osc_mode_reg <= INT_OSC_MODE_STABLE;
	end

	// read multiplexer
	always_comb
	begin
		rd_hit  = 1'b1;
		rd_word = 32'h00000000;
		unique case (s_axi_araddr)
			OFF_CLK_CTL:  rd_word = {8'h00, stabilization_time_select_reg,
				main_osc_control_reg, cpu_clock_control_reg};
			OFF_CLK_MODE: rd_word = {internal_osc_mode_reg, stabilization_counter_status_reg,
				main_clock_mode_reg, clock_operation_mode_reg};
			OFF_PORT_LAT: rd_word = 32'(port_latch_reg);
			OFF_PORT_DIR: rd_word = 32'(port_direction_reg);
			OFF_MEM_SIZE: rd_word = {16'h0000, expansion_ram_size_switch_reg,
				memory_size_switch_reg};
			OFF_CORE:     rd_word = {stack_pointer_reg, 8'h00, program_status_word_reg};
			OFF_TMR_CNT:  rd_word = {timer_compare_reg, timer_count_reg};
			OFF_TMR_CTL:  rd_word = timer_ctl_reg;
			OFF_STATUS:   rd_word = {program_counter, 11'h000, clk_ctl.hiosc_stable,
				ram_retain, state_reg};
			default:      rd_hit = 1'b0;
		endcase
	end

	assign wr_hit = s_axi_awaddr <= OFF_TMR_CTL && s_axi_awaddr[1:0] == 2'h0;

	// ------------------------------------------------------------
	// axi4-lite handshakes
	// ------------------------------------------------------------

	// address and data taken together, response a cycle later
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= AXI_OKAY;
		end
		else if (ce)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid)
			begin
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (wr_en)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? AXI_OKAY : AXI_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// read answered the cycle after the address is taken
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= AXI_OKAY;
		end
		else if (ce)
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_hit ? AXI_OKAY : AXI_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ===== tb/mrs_pin_src.sv
// reset pin driver: holds the pin low for len cycles after go
`timescale 1ns/1ps
`default_nettype none
module mrs_pin_src
(
	input wire logic       clk,      // clock
	input wire logic       go,       // start pulse
	input wire logic [7:0] len,      // low cycles
	output logic           ext_rst_n // pin, low
);
	logic [7:0] cnt_reg = 8'h00;
	// count the low time down; pin is high when idle
	always @(posedge clk)
		cnt_reg <= go ? len : cnt_reg - 8'(cnt_reg != 8'h00);
	assign ext_rst_n = cnt_reg == 8'h00;
endmodule
`default_nettype wire

// ===== tb/mrs_seq_asserts.sv
// port checks of the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module mrs_seq_asserts
	import mrs_pkg::*;
#(
	parameter int unsigned PROC_CYC = 5, // processing
	parameter int unsigned STAB_CYC = 8  // osc wait
)
(
	input wire logic        clk,             // clock
	input wire logic        sys_rst,         // reset
	input wire logic        ext_rst_n,       // pin
	input wire logic        wdt_ovf,         // request
	input wire logic        poc_req,         // request
	input wire logic        lvd_req,         // request
	input wire logic [7:0]  vector_lo,       // vector
	input wire logic [7:0]  vector_hi,       // vector
	input wire logic        core_rst,        // reset out
	input wire logic        wdt_rst,         // reset out
	input wire logic        lvd_rst,         // reset out
	input wire mrs_clk_s    clk_ctl,         // enables
	input wire logic [15:0] program_counter, // pc
	input wire logic        pc_load,         // pulse
	input wire logic [31:0] port_out,        // levels
	input wire logic [31:0] port_oe          // enables
);
	localparam int PLO = PROC_CYC;
	localparam int PHI = PROC_CYC + 2;
	localparam int SLO = STAB_CYC - 1;
	localparam int SHI = STAB_CYC + 3;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// each property ties an output to its cause
	property p_or; wdt_ovf || poc_req || lvd_req |=> core_rst; endproperty
	a_or: assert property (p_or) else $error("request gave no reset");
	property p_wdt; wdt_rst == core_rst; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset differs");
	property p_lvd; lvd_req && !wdt_ovf && !poc_req && ext_rst_n && !lvd_rst |=> !lvd_rst;
	endproperty
	a_lvd: assert property (p_lvd) else $error("detector reset itself");
	property p_port; core_rst |=> port_oe == 32'h1 && port_out == 32'h0; endproperty
	a_port: assert property (p_port) else $error("ports wrong in reset");
	property p_clk; core_rst |=> clk_ctl == 8'h01; endproperty
	a_clk: assert property (p_clk) else $error("clocks run in reset");
	property p_pc; pc_load |-> program_counter == {$past(vector_hi), $past(vector_lo)}
		##1 !pc_load && clk_ctl.cpu_clk_en; endproperty
	a_pc: assert property (p_pc) else $error("vector load wrong");
	property p_proc; @(posedge clk) disable iff (sys_rst || core_rst)
		$fell(core_rst) |-> ##[PLO:PHI] pc_load; endproperty
	a_proc: assert property (p_proc) else $error("processing time wrong");
	property p_stab; @(posedge clk) disable iff (sys_rst || core_rst)
		$fell(core_rst) |-> !clk_ctl.hiosc_stable ##[SLO:SHI] clk_ctl.hiosc_stable; endproperty
	a_stab: assert property (p_stab) else $error("osc wait wrong");
	c_wdt: cover property (wdt_ovf ##1 core_rst);
	c_lvd: cover property (lvd_req && !lvd_rst);
	c_load: cover property (pc_load);
endmodule
bind mrs_reset_sequencer mrs_seq_asserts #(.PROC_CYC(PROC_CYC), .STAB_CYC(STAB_CYC)) u_chk (
	.clk, .sys_rst, .ext_rst_n, .wdt_ovf, .poc_req, .lvd_req, .vector_lo, .vector_hi,
	.core_rst, .wdt_rst, .lvd_rst, .clk_ctl, .program_counter, .pc_load, .port_out, .port_oe);
`default_nettype wire

// ===== tb/test_mcu_reset_sequencer.sv
// reset sequencer bench with a register reset model
`timescale 1ns/1ps
`default_nettype none
module test_mcu_reset_sequencer;
	import mrs_pkg::*;
	localparam int PD = 3;
	localparam int PC = 5;
	localparam int SC = 30;
	logic clk = 1'h0, sys_rst = 1'h1, go = 1'h0, standby = 1'h0;
	logic awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
	logic [2:0] req = 3'h0;
	logic [7:0] vlo = 8'h00, vhi = 8'h00, aw = 8'h00;
	logic [31:0] wd = 32'h0, rd, pout, poe;
	logic ext_rst_n, core_rst, pc_load, awr, wr, bv, arr, rv;
	logic [1:0] br, rr;
	logic [15:0] pcv;
	mrs_clk_s cc;
	int miscompares = 0, compares = 0, cyc = 0;
	logic [31:0] tab [8] = '{32'h58001, 0, 0, 32'hFFFFFFFE, 32'hCCF, 0, 0, 0};
	mrs_pin_src src (.clk, .go, .len(8'h14), .ext_rst_n);
	mrs_reset_sequencer #(.PIN_DLY(PD), .PROC_CYC(PC), .STAB_CYC(SC)) uut (
		.clk, .sys_rst, .ce(1'h1), .ext_rst_n, .wdt_ovf(req[0]), .poc_req(req[1]),
		.lvd_req(req[2]), .standby, .vector_lo(vlo), .vector_hi(vhi), .core_rst,
		.wdt_rst(), .lvd_rst(), .ram_retain(), .clk_ctl(cc), .program_counter(pcv), .pc_load,
		.port_out(pout), .port_oe(poe), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_araddr(aw), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
	// clock and run limit
	always #50 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			miscompares++;
			conclude();
		end
	end
	task automatic conclude();
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	// one write (w=1) or read; each channel dropped once taken
	task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic [1:0] e);
		int n;
		n = 0;
		@(posedge clk);
		aw <= a;
		wd <= d;
		awv <= w;
		wv <= w;
		bre <= w;
		arv <= !w;
		rre <= !w;
		do
		begin
			@(posedge clk);
			n++;
			if (awr === 1'h1) awv <= 1'h0;
			if (wr === 1'h1) wv <= 1'h0;
			if (arr === 1'h1) arv <= 1'h0;
		end while ((w ? bv : rv) !== 1'h1 && n < 50);
		bre <= 1'h0;
		rre <= 1'h0;
		chk("resp", e, w ? br : rr);
		if (!w) chk("rdata", d & m, rd & m);
	endtask
	// edges until the chosen signal reads v
	task automatic wait_for(input int k, input logic v, output int c);
		c = 0;
		do
		begin
			@(posedge clk);
			c++;
		end while ((k == 0 ? ext_rst_n : k == 1 ? core_rst : pc_load) !== v && c < 900);
	endtask
	// wait for run and compare every register with its reset value
	task automatic boot(input logic [31:0] e14, input logic [31:0] m20);
		int c;
		if (core_rst !== 1'h0) wait_for(1, 1'h0, c);
		wait_for(2, 1'h1, c);
		chk("proc_cycles", PC + 1, c);
		chk("vector", {vhi, vlo}, pcv);
		for (int i = 0; i < 8; i++)
			axi(0, 8'(i * 4), i == 5 ? e14 : tab[i], '1, AXI_OKAY);
		chk("cpu_clk", 1, cc.cpu_clk_en);
		chk("x1_off", 0, cc.x1_en);
		repeat (SC) @(posedge clk);
		axi(0, 8'h04, 32'h80000000, '1, AXI_OKAY);
		axi(0, 8'h20, {vhi, vlo, 11'h0, 1'h1, standby, 3'h4}, m20, AXI_OKAY);
	endtask
	initial
	begin
		logic [31:0] d;
		logic [15:0] sp;
		int c;
		d = $urandom(32'h93525de0);
		vlo <= 8'($urandom);
		vhi <= 8'($urandom);
		repeat (3) @(posedge clk);
		sys_rst <= 1'h0;
		boot(32'h2, 32'hFFFFFFF7);
		axi(0, 8'h24, 0, '1, AXI_SLVERR);
		axi(1, 8'h20, 0, 0, AXI_SLVERR);
		for (int s = 0; s < 4; s++)
		begin
			sp = 16'($urandom);
			standby <= 1'($urandom);
			{vhi, vlo} <= 16'($urandom);
			for (int i = 0; i < 8; i++)
			begin
				d = $urandom;
				d = i == 0 ? 32'h50001 : i == 2 ? d | 1 : i == 3 ? d & ~1 : i == 5 ? {sp, d[15:0]} : d;
				axi(1, 8'(i * 4), d, 0, AXI_OKAY);
			end
			chk("mirror_high", 2'h3, {poe[0], pout[0]});
			chk("x1_on", 1, cc.x1_en);
			go <= s == 0;
			req <= s == 0 ? 3'h0 : 3'h1 << (s - 1);
			@(posedge clk);
			go <= 1'h0;
			if (s == 0) wait_for(0, 1'h0, c);
			if (s == 0) wait_for(1, 1'h1, c);
			if (s == 0) chk("pin_assert", PD + 2, c);
			repeat (4) @(posedge clk);
			req <= 3'h0;
			chk("mirror_low", 2'h2, {poe[0], pout[0]});
			if (s == 0) wait_for(0, 1'h1, c);
			if (s == 0) wait_for(1, 1'h0, c);
			if (s == 0) chk("pin_release", PD + 2, c);
			boot({sp, 16'h0002}, '1);
		end
		conclude();
	end
endmodule
`default_nettype wire
